// file: verilog/cfd_pkg.sv
package cfd_pkg;
    // register byte addresses on the avalon bus (one word each)
    localparam logic [3:0] OFS_BOOT_CFG   = 4'h0;
    localparam logic [3:0] OFS_GEN_CFG    = 4'h4;
    localparam logic [3:0] OFS_WDT_CFG    = 4'h8;
    localparam logic [3:0] OFS_POR_CFG    = 4'hc;
    localparam logic [3:0] OFS_CTRL       = 4'h0; // index 4 region, see top
    localparam logic [4:0] ADR_CTRL       = 5'h10;
    localparam logic [4:0] ADR_STATUS     = 5'h14;
    localparam logic [4:0] ADR_PROBE      = 5'h18;

    // configuration word shape
    localparam int CFG_WORD_W = 24;
    localparam int CFG_DATA_W = 16;

    // boot segment word fields
    localparam int BWP_POS = 0;
    localparam int BSS_LSB = 1;
    // general segment word fields
    localparam int GWP_POS = 0;
    localparam int GSS_LSB = 1;
    // watchdog word fields
    localparam int WPOST_LSB = 0;
    localparam int WPRE_POS  = 4;
    localparam int WWIN_POS  = 6;
    localparam int WFEN_POS  = 7;
    // power-on word field
    localparam int POWERON_DELAY_TIMER_LSB = 0;

    // boot size codes
    localparam logic [2:0] BSS_SMALL_STD = 3'h6;
    localparam logic [2:0] BSS_SMALL_HI  = 3'h2;
    localparam logic [2:0] BSS_MED_STD   = 3'h5;
    localparam logic [2:0] BSS_MED_HI    = 3'h1;
    // general security codes
    localparam logic [1:0] GSS_NONE = 2'h3;
    localparam logic [1:0] GSS_STD  = 2'h2;

    // segment end addresses
    localparam logic [23:0] BOOT_END_SMALL = 24'h0003ff;
    localparam logic [23:0] BOOT_END_MED   = 24'h000fff;

    // watchdog prescale ratios as log2
    localparam logic [3:0] PRE_LOG_HI = 4'h7; // 1:128
    localparam logic [3:0] PRE_LOG_LO = 4'h5; // 1:32

    // power-on timer: 2 ms at code 001, doubling per code
    localparam int  CLK_MHZ      = 100;
    localparam int  POWERON_DELAY_TIMER_BASE_MS = 2;
    localparam int  POWERON_DELAY_TIMER_BASE_CYC = POWERON_DELAY_TIMER_BASE_MS * 1000 * CLK_MHZ;

    // loader timing
    localparam int  LOAD_CYCLES = 4;

    typedef enum logic [1:0] {
        BOOT_NONE, BOOT_STD, BOOT_HIGH
    } cfd_sec_t;
endpackage : cfd_pkg

// file: verilog/cfd_word_rom.sv
`timescale 1ns/1ps
// holds the four latched configuration words; read data registered
module cfd_word_rom #(
    parameter int WORD_W = 24,
    parameter int DEPTH  = 4
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WORD_W-1:0]        wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output      logic [WORD_W-1:0]        rdData
);
    initial begin
        if (DEPTH < 2 || WORD_W < 16) $error("cfd_word_rom bad params");
    end

    logic [WORD_W-1:0] memQ [DEPTH];

    // storage written only by the reset-time loader
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memQ[wrAddr] <= wrData;
        end
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= memQ[rdAddr];
        end
    end
endmodule : cfd_word_rom

// file: verilog/cfd_poweron_delay_timer_timer.sv
`timescale 1ns/1ps
// power-on delay timer: counts base periods, then flags done
module cfd_poweron_delay_timer_timer #(
    parameter int BASE_CYC = 200000
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] code,
    output      logic       done
);
    initial begin
        if (BASE_CYC < 1) $error("cfd_poweron_delay_timer_timer bad BASE_CYC");
    end

    localparam int BW = $clog2(BASE_CYC + 1);
    logic [BW-1:0] baseQ, baseD;
    logic [6:0]    unitQ, unitD;
    logic          runQ, runD, doneD;
    logic [6:0]    target;

    // 001 -> 1 base period (2 ms), doubling per code up to 64 (128 ms)
    assign target = 7'h01 << (code - 3'h1);

    // base divider gives a one-cycle tick, unit counter counts ticks
    always_comb begin
        baseD = baseQ;
        unitD = unitQ;
        runD  = runQ;
        doneD = done;
        if (start) begin
            baseD = '0;
            unitD = '0;
            runD  = (code != 3'h0);
            doneD = (code == 3'h0); // timer disabled
        end else if (runQ) begin
            if (baseQ == BW'(BASE_CYC - 1)) begin
                baseD = '0;
                unitD = unitQ + 7'h01;
                if (unitQ + 7'h01 == target) begin
                    runD  = 1'b0;
                    doneD = 1'b1;
                end
            end else begin
                baseD = baseQ + BW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baseQ <= '0;
            unitQ <= '0;
            runQ  <= 1'b0;
            done  <= 1'b0;
        end else begin
            baseQ <= baseD;
            unitQ <= unitD;
            runQ  <= runD;
            done  <= doneD;
        end
    end
endmodule : cfd_poweron_delay_timer_timer

// file: verilog/cfd_config_decode.sv
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - boot write-protect bit 1 lets boot segment be written, 0 blocks writes
// - boot size codes x11 and x00 mean no boot segment, no protection
// - code 110 gives small boot segment, standard security, ending 0003FFH
// - code 010 gives small boot segment, high security, ending 0003FFH
// - code 101 gives medium boot segment, standard security, ending 000FFFH
// - medium high-security segment ending 000FFFH selectable; code taken 001
// - general write-protect bit 1 allows writes, 0 protects general segment
// - general security 11 means none; 0x codes reserved, treated as none
// - general security 10 gives standard security from boot end to flash end
// - watchdog fuse 1: watchdog always runs, software enable ignored
// - watchdog fuse 0: software enable starts, stops watchdog and RC source
// - window fuse 1 selects non-window mode, 0 selects window mode
// - prescaler fuse 1 divides by 128, 0 divides by 32
// - postscaler 1111 gives 1:32768, 1110 gives 1:16384
// - power timer 111 is 128 ms, halving per code to 2 ms, 000 off
// - config words are 24 bits, only lower 16 carry data
module cfd_config_decode
    import cfd_pkg::*;
#(
    parameter int POWERON_DELAY_TIMER_BASE = cfd_pkg::POWERON_DELAY_TIMER_BASE_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // raw configuration words from the fuse array
    input  wire logic [CFG_WORD_W-1:0] bootCfgWord,
    input  wire logic [CFG_WORD_W-1:0] genCfgWord,
    input  wire logic [CFG_WORD_W-1:0] wdtCfgWord,
    input  wire logic [CFG_WORD_W-1:0] porCfgWord,
    // avalon-mm slave
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output      logic [31:0]           avs_readdata,
    output      logic                  avs_waitrequest,
    // decoded outputs
    output      logic                  bootWriteAllow,
    output      cfd_sec_t              bootSecurity,
    output      logic [23:0]           bootEndAddr,
    output      logic                  generalWriteAllow,
    output      logic                  generalSecure,
    output      logic                  watchdogRun,
    output      logic                  lowPowerRcEnable,
    output      logic                  watchdogWindowMode,
    output      logic [3:0]            watchdogPrescaleLog2,
    output      logic [3:0]            watchdogPostscaleLog2,
    output      logic                  poweronDelayDone
);
    import cfd_pkg::*;

    initial begin
        if (POWERON_DELAY_TIMER_BASE < 1) $error("cfd_config_decode bad POWERON_DELAY_TIMER_BASE");
    end

    typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_WAIT, ST_ANS} cfd_state_t;

    // lower 16 data bits kept, top byte forced to zero
    function automatic logic [CFG_WORD_W-1:0]
        cfgMask(input logic [CFG_WORD_W-1:0] w);
        cfgMask = {8'h00, w[CFG_DATA_W-1:0]};
    endfunction : cfgMask

    // boot size code to security class
    function automatic cfd_sec_t bootClass(input logic [2:0] c);
        if (c == BSS_SMALL_STD || c == BSS_MED_STD) begin
            bootClass = BOOT_STD;
        end else if (c == BSS_SMALL_HI || c == BSS_MED_HI) begin
            bootClass = BOOT_HIGH;
        end else begin
            bootClass = BOOT_NONE;
        end
    endfunction : bootClass

    cfd_state_t         stQ, stD;
    logic [1:0]         ldIdxQ, ldIdxD;
    logic [15:0]        bootQ, genQ, wdtQ, porQ;
    logic [15:0]        bootD, genD, wdtD, porD;
    logic               swEnQ, swEnD;
    logic [31:0]        rdQ, rdD;
    logic               waitQ, waitD;
    logic               romWr;
    logic [23:0]        romWrData;
    logic [1:0]         romRdAddr;
    logic [23:0]        romRdData;
    logic               pwrtStart;
    logic               pwrtDone;
    logic [2:0]         bss;
    logic [1:0]         gss;

    // snapshot of the fuse words also kept readable by software
    cfd_word_rom #(.WORD_W(CFG_WORD_W), .DEPTH(4)) uRom (
        .clk    (ref_clk),
        .rst    (sys_rst),
        .wrEn   (romWr),
        .wrAddr (ldIdxQ),
        .wrData (romWrData),
        .rdAddr (romRdAddr),
        .rdData (romRdData)
    );

    // code from the next value: on the start cycle the shadow still
    // holds its reset ones, which would mask a disabled timer
    cfd_poweron_delay_timer_timer #(.BASE_CYC(POWERON_DELAY_TIMER_BASE)) uPwrt (
        .clk   (ref_clk),
        .rst   (sys_rst),
        .start (pwrtStart),
        .code  (porD[POWERON_DELAY_TIMER_LSB +: 3]),
        .done  (pwrtDone)
    );

    // loader writes one word per cycle into the rom during ST_LOAD
    always_comb begin
        case (ldIdxQ)
            2'h0:    romWrData = cfgMask(bootCfgWord);
            2'h1:    romWrData = cfgMask(genCfgWord);
            2'h2:    romWrData = cfgMask(wdtCfgWord);
            default: romWrData = cfgMask(porCfgWord);
        endcase
    end
    assign romWr     = (stQ == ST_LOAD);
    assign romRdAddr = avs_address[3:2];
    assign pwrtStart = (stQ == ST_LOAD) && (ldIdxQ == 2'h3);
    assign bss       = bootQ[BSS_LSB +: 3];
    assign gss       = genQ[GSS_LSB +: 2];

    // fuse shadows update only while loading; frozen afterwards
    always_comb begin
        stD    = stQ;
        ldIdxD = ldIdxQ;
        bootD  = bootQ;
        genD   = genQ;
        wdtD   = wdtQ;
        porD   = porQ;
        swEnD  = swEnQ;
        rdD    = rdQ;
        waitD  = 1'b1;
        case (stQ)
            ST_LOAD: begin
                ldIdxD = ldIdxQ + 2'h1;
                case (ldIdxQ)
                    2'h0:    bootD = bootCfgWord[15:0];
                    2'h1:    genD  = genCfgWord[15:0];
                    2'h2:    wdtD  = wdtCfgWord[15:0];
                    default: begin
                        porD = porCfgWord[15:0];
                        stD  = ST_RUN;
                    end
                endcase
            end
            ST_RUN: begin
                // rom read data are registered, so one extra wait cycle
                if (avs_read || avs_write) begin
                    stD = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // rom output now holds the addressed word
                stD = ST_ANS;
                rdD = 32'h0000_0000;
                if (avs_address < ADR_CTRL) begin
                    rdD = {8'h00, romRdData}; // config words read-only
                end else if (avs_address == ADR_CTRL) begin
                    rdD = {31'h0, swEnQ};
                end else if (avs_address == ADR_STATUS) begin
                    rdD = {29'h0, pwrtDone, watchdogRun, 1'b1};
                end
            end
            default: begin
                // write lands at the edge that ends the answer cycle
                stD = ST_RUN;
                if (avs_write && avs_byteenable[0]
                    && avs_address == ADR_CTRL) begin
                    swEnD = avs_writedata[0];
                end
            end
        endcase
        waitD = (stD != ST_ANS);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stQ    <= ST_LOAD;
            ldIdxQ <= 2'h0;
            bootQ  <= 16'hffff;
            genQ   <= 16'hffff;
            wdtQ   <= 16'hffff;
            porQ   <= 16'hffff;
            swEnQ  <= 1'b0;
            rdQ    <= 32'h0000_0000;
            waitQ  <= 1'b1;
        end else begin
            stQ    <= stD;
            ldIdxQ <= ldIdxD;
            bootQ  <= bootD;
            genQ   <= genD;
            wdtQ   <= wdtD;
            porQ   <= porD;
            swEnQ  <= swEnD;
            rdQ    <= rdD;
            waitQ  <= waitD;
        end
    end

    // waitrequest low exactly in the answer cycle, readdata valid there
    always_comb begin
        avs_waitrequest = waitQ;
        avs_readdata    = rdQ;
    end

    // decoded controls, all registered from the frozen shadows, swEnQ and the timer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bootWriteAllow        <= 1'b0;
            bootSecurity          <= BOOT_NONE;
            bootEndAddr           <= 24'h000000;
            generalWriteAllow     <= 1'b0;
            generalSecure         <= 1'b0;
            watchdogRun           <= 1'b0;
            lowPowerRcEnable      <= 1'b0;
            watchdogWindowMode    <= 1'b0;
            watchdogPrescaleLog2  <= PRE_LOG_LO;
            watchdogPostscaleLog2 <= 4'h0;
            poweronDelayDone      <= 1'b0;
        end else begin
            bootWriteAllow    <= bootQ[BWP_POS];
            bootSecurity      <= bootClass(bss);
            if (bss == BSS_SMALL_STD || bss == BSS_SMALL_HI) begin
                bootEndAddr <= BOOT_END_SMALL;
            end else if (bss == BSS_MED_STD || bss == BSS_MED_HI) begin
                bootEndAddr <= BOOT_END_MED;
            end else begin
                bootEndAddr <= 24'h000000;
            end
            generalWriteAllow <= genQ[GWP_POS];
            generalSecure     <= (gss == GSS_STD);
            // fuse forces the watchdog and its rc on
            watchdogRun       <= wdtQ[WFEN_POS] | swEnQ;
            lowPowerRcEnable  <= wdtQ[WFEN_POS] | swEnQ;
            watchdogWindowMode <= ~wdtQ[WWIN_POS];
            watchdogPrescaleLog2 <= wdtQ[WPRE_POS] ? PRE_LOG_HI
                                                   : PRE_LOG_LO;
            // log2 ratio equals the code: 1111 is 2^15 = 32768
            watchdogPostscaleLog2 <= wdtQ[WPOST_LSB +: 4];
            poweronDelayDone  <= pwrtDone && stQ != ST_LOAD;
        end
    end

    a_wdt_forced: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (stQ != ST_LOAD && wdtQ[WFEN_POS]) |=> watchdogRun)
        else $error("watchdog not forced on");
    a_wdt_soft: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!wdtQ[WFEN_POS] && !swEnQ) |=> !watchdogRun)
        else $error("watchdog ran without enable");
    a_boot_wp: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(stQ) != ST_LOAD |-> bootWriteAllow == $past(bootQ[0]))
        else $error("boot write permit wrong");
    a_boot_none: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bss[1:0] == 2'b11 || bss[1:0] == 2'b00) |=>
        bootSecurity == BOOT_NONE && bootEndAddr == 24'h0)
        else $error("boot segment should be absent");
    a_boot_small: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bss == 3'b110 |=> bootEndAddr == 24'h0003ff
        && bootSecurity == BOOT_STD)
        else $error("small std boot decode wrong");
    a_boot_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bss == 3'b010 |=> bootSecurity == BOOT_HIGH)
        else $error("small high boot decode wrong");
    a_gen_sec: assert property (@(posedge ref_clk) disable iff (sys_rst)
        gss != 2'b10 |=> !generalSecure)
        else $error("general security decode wrong");
    a_win_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wdtQ[WWIN_POS] |=> !watchdogWindowMode)
        else $error("window mode decode wrong");
    a_pre_sel: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wdtQ[WPRE_POS] |=> watchdogPrescaleLog2 == 4'h7)
        else $error("prescaler decode wrong");
    a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
        stQ == ST_RUN |=> $stable(wdtQ) && $stable(bootQ))
        else $error("config shadow changed while running");
    a_bus_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (stQ == ST_RUN && (avs_read || avs_write))
        |-> ##2 !avs_waitrequest)
        else $error("bus answer late");
endmodule : cfd_config_decode

// file: sim/cfd_fuse_programmer.sv
`timescale 1ns/1ps
// stands in for the external programmer that burns the fuse words
module cfd_fuse_programmer (
    output logic [cfd_pkg::CFG_WORD_W-1:0] bootWord,
    output logic [cfd_pkg::CFG_WORD_W-1:0] genWord,
    output logic [cfd_pkg::CFG_WORD_W-1:0] wdtWord,
    output logic [cfd_pkg::CFG_WORD_W-1:0] porWord
);
    import cfd_pkg::*;

    // blank array until the bench burns it
    initial begin
        bootWord = '0;
        genWord  = '0;
        wdtWord  = '0;
        porWord  = '0;
    end

    // unused top byte left erased (ones), so a decoder that
    // leaks it into the settings is caught
    task automatic burn(input logic [15:0] b,
                        input logic [15:0] g,
                        input logic [15:0] w,
                        input logic [15:0] p);
        bootWord <= {8'hff, b};
        genWord  <= {8'hff, g};
        wdtWord  <= {8'hff, w};
        porWord  <= {8'hff, p};
    endtask : burn
endmodule : cfd_fuse_programmer

// file: sim/test_config_fuse_decode.sv
`timescale 1ns/1ps
module test_config_fuse_decode;
    import cfd_pkg::*;
    localparam int BASE = 10; // short power timer base for sim

    logic        refClk = 1'b0;
    logic        sysRst = 1'b1;
    logic [23:0] bootW, genW, wdtW, porW;
    logic [4:0]  avsAddress = 5'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0]  avsByteenable = 4'hf;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        bootWriteAllow, generalWriteAllow, generalSecure;
    cfd_sec_t    bootSecurity;
    logic [23:0] bootEndAddr;
    logic        watchdogRun, lowPowerRcEnable, watchdogWindowMode;
    logic [3:0]  watchdogPrescaleLog2, watchdogPostscaleLog2;
    logic        poweronDelayDone;
    int          mismatches = 0;
    int          compares = 0;
    logic [15:0] rnd = 16'h0005;
    logic [15:0] cfg [4]; // boot, general, watchdog, power words

    always #5 refClk = ~refClk;

    cfd_fuse_programmer i_prog (
        .bootWord(bootW), .genWord(genW), .wdtWord(wdtW), .porWord(porW)
    );

    cfd_config_decode #(.POWERON_DELAY_TIMER_BASE(BASE)) i_dut (
        .ref_clk(refClk), .sys_rst(sysRst),
        .bootCfgWord(bootW), .genCfgWord(genW),
        .wdtCfgWord(wdtW), .porCfgWord(porW),
        .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .bootWriteAllow(bootWriteAllow), .bootSecurity(bootSecurity),
        .bootEndAddr(bootEndAddr), .generalWriteAllow(generalWriteAllow),
        .generalSecure(generalSecure), .watchdogRun(watchdogRun),
        .lowPowerRcEnable(lowPowerRcEnable),
        .watchdogWindowMode(watchdogWindowMode),
        .watchdogPrescaleLog2(watchdogPrescaleLog2),
        .watchdogPostscaleLog2(watchdogPostscaleLog2),
        .poweronDelayDone(poweronDelayDone)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic wrap_up();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic [4:0] a, input logic wr,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge refClk);
        avsAddress    <= a;
        avsRead       <= !wr;
        avsWrite      <= wr;
        avsWritedata  <= wd;
        avsByteenable <= be;
        do begin
            @(posedge refClk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 40);
        rd = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        if (avsWaitrequest !== 1'b0) begin
            mismatches++;
            wrap_up();
        end
    endtask : bus

    // reference decode of the stored words against the live outputs
    task automatic check_decode();
        cfd_sec_t    es;
        logic [23:0] ee;
        es = BOOT_NONE;
        ee = 24'h0;
        case (cfg[0][3:1])
            3'h6: begin es = BOOT_STD;  ee = 24'h0003ff; end
            3'h2: begin es = BOOT_HIGH; ee = 24'h0003ff; end
            3'h5: begin es = BOOT_STD;  ee = 24'h000fff; end
            3'h1: begin es = BOOT_HIGH; ee = 24'h000fff; end
            default: ;
        endcase
        check(32'(bootSecurity), 32'(es));
        check(32'(bootEndAddr), 32'(ee));
        check(32'(bootWriteAllow), 32'(cfg[0][0]));
        check(32'(generalWriteAllow), 32'(cfg[1][0]));
        check(32'(generalSecure), 32'(cfg[1][2:1] == 2'b10));
        check(32'(watchdogWindowMode), 32'(!cfg[2][6]));
        check(32'(watchdogPrescaleLog2), cfg[2][4] ? 32'h7 : 32'h5);
        check(32'(watchdogPostscaleLog2), 32'(cfg[2][3:0]));
    endtask : check_decode

    initial begin
        logic [31:0] rd;
        logic [3:0]  post;
        int          n;
        int          d;
        for (int k = 0; k < 8; k++) begin
            // every boot and timer code once, every general code twice, watchdog fuse alternating, postscaler 1111/1110/0000 first; rest random
            rnd = lfsr(rnd);
            cfg[0] = {rnd[15:4], 3'(k), rnd[0]};
            rnd = lfsr(rnd);
            cfg[1] = {rnd[15:3], 2'(k), rnd[0]};
            rnd = lfsr(rnd);
            post = (k == 0) ? 4'hf : (k == 1) ? 4'he : (k == 2) ? 4'h0
                 : rnd[3:0];
            cfg[2] = {rnd[15:8], 1'(k), rnd[6:4], post};
            rnd = lfsr(rnd);
            cfg[3] = {rnd[15:3], 3'(k)};
            i_prog.burn(cfg[0], cfg[1], cfg[2], cfg[3]);
            @(posedge refClk);
            sysRst <= 1'b1;
            repeat (16) @(posedge refClk);
            sysRst <= 1'b0;
            // power timer: cycles from release until done rises
            d = (k == 0) ? 0 : (BASE << (k - 1));
            n = 0;
            while (poweronDelayDone !== 1'b1 && n < 1000) begin
                @(posedge refClk);
                n++;
            end
            if (n >= 1000) begin
                mismatches++;
                wrap_up();
            end
            check(32'(n >= d && n <= d + 12), 32'h1);
            check_decode();
            for (int a = 0; a < 4; a++) begin
                bus(5'(a * 4), 1'b0, 32'h0, 4'hf, rd);
                check(rd, {16'h0, cfg[a]});
            end
            // read-only word ignores writes; unmapped reads zero
            bus(5'h00, 1'b1, 32'hffffffff, 4'hf, rd);
            bus(5'h00, 1'b0, 32'h0, 4'hf, rd);
            check(rd, {16'h0, cfg[0]});
            bus(5'h1c, 1'b0, 32'h0, 4'hf, rd);
            check(rd, 32'h0);
            // software enable on, an off write with byte lane 0 masked is ignored, then off
            bus(5'h10, 1'b1, 32'h1, 4'h1, rd);
            bus(5'h10, 1'b1, 32'h0, 4'he, rd);
            bus(5'h10, 1'b0, 32'h0, 4'hf, rd);
            check(32'(rd[0]), 32'h1);
            check(32'(watchdogRun), 32'h1);
            check(32'(lowPowerRcEnable), 32'h1);
            bus(5'h10, 1'b1, 32'h0, 4'h1, rd);
            bus(5'h14, 1'b0, 32'h0, 4'hf, rd);
            check(rd, {29'h0, 1'b1, cfg[2][7], 1'b1});
            check(32'(watchdogRun), 32'(cfg[2][7]));
            check(32'(lowPowerRcEnable), 32'(cfg[2][7]));
            // reburn while running: settings must not follow
            i_prog.burn(~cfg[0], ~cfg[1], ~cfg[2], ~cfg[3]);
            repeat (8) @(posedge refClk);
            check_decode();
            bus(5'h08, 1'b0, 32'h0, 4'hf, rd);
            check(rd, {16'h0, cfg[2]});
        end
        wrap_up();
    end
endmodule : test_config_fuse_decode
